// [tmcc_pkg.sv]
`default_nettype none
package tmcc_pkg;
    localparam int NCH = 2;
    localparam int AW  = 5;
    localparam int DW  = 32;

    // Avalon byte addresses, one word per register
    localparam logic [AW-1:0] OFS_SC0 = 5'h00;
    localparam logic [AW-1:0] OFS_SC1 = 5'h04;
    localparam logic [AW-1:0] OFS_V0H = 5'h08;
    localparam logic [AW-1:0] OFS_V0L = 5'h0c;
    localparam logic [AW-1:0] OFS_V1H = 5'h10;
    localparam logic [AW-1:0] OFS_V1L = 5'h14;

    // Status/control byte layout
    localparam int BIT_FLAG = 7;
    localparam int BIT_IE   = 6;
    localparam int BIT_BUF  = 5;
    localparam int BIT_MSA  = 4;
    localparam int BIT_ELSB = 3;
    localparam int BIT_ELSA = 2;
    localparam int BIT_TOV  = 1;
    localparam int BIT_MAX  = 0;

    localparam logic [7:0]  SC_RST    = 8'h00;
    localparam logic [7:0]  SC_WMASK  = 8'h7f;
    localparam logic [7:0]  SC1_WMASK = 8'h5f;
    localparam logic [15:0] VAL_RST   = 16'h0000;

    // Edge/level codes: capture edge or compare action
    localparam logic [1:0] ELS_OFF  = 2'h0;
    localparam logic [1:0] ELS_RISE = 2'h1;
    localparam logic [1:0] ELS_FALL = 2'h2;
    localparam logic [1:0] ELS_ANY  = 2'h3;
    localparam logic [1:0] ACT_TOG  = 2'h1;
    localparam logic [1:0] ACT_CLR  = 2'h2;
    localparam logic [1:0] ACT_SET  = 2'h3;
endpackage
`default_nettype wire

// [tmcc_edge.sv]
`timescale 1ns/1ps
`default_nettype none
module tmcc_edge (
    input  wire logic       mclk,
    input  wire logic       reset_n,
    input  wire logic       pin_in,
    input  wire logic [1:0] sel,
    output logic            edge_hit
);
    import tmcc_pkg::*;

    typedef struct packed {
        logic prev;
    } tmcc_edge_t;

    tmcc_edge_t s_reg;
    tmcc_edge_t s_next;
    logic       rise;
    logic       fall;

    assign rise = pin_in & ~s_reg.prev;
    assign fall = ~pin_in & s_reg.prev;

    always_comb begin
        s_next      = s_reg;
        s_next.prev = pin_in;
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // Edge choice for capture
    assign edge_hit = ((sel == ELS_RISE) & rise)
                    | ((sel == ELS_FALL) & fall)
                    | ((sel == ELS_ANY) & (rise | fall));

    a_rise_only: assert property (@(posedge mclk) disable iff (!reset_n)
        (edge_hit && sel == ELS_RISE) |-> (pin_in && !$past(pin_in)))
        else $error("capture on wrong edge");
endmodule
`default_nettype wire

// [tmcc_pwm.sv]
`timescale 1ns/1ps
`default_nettype none
module tmcc_pwm (
    input  wire logic       mclk,
    input  wire logic       reset_n,
    input  wire logic       enabled,
    input  wire logic       preset_low,
    input  wire logic [1:0] action,
    input  wire logic       tov,
    input  wire logic       max_duty,
    input  wire logic       overflow,
    input  wire logic       match,
    output logic            level
);
    import tmcc_pkg::*;

    typedef struct packed {
        logic level;
        logic max_eff;
    } tmcc_pwm_t;

    tmcc_pwm_t s_reg;
    tmcc_pwm_t s_next;
    logic      max_on;

    // Full duty only counts from a period boundary
    assign max_on = s_reg.max_eff & tov & (action == ACT_CLR);

    always_comb begin
        s_next = s_reg;
        if (overflow) begin
            s_next.max_eff = max_duty;
        end
        if (!enabled) begin
            // Disconnected: hold the preset until the pin is handed over
            s_next.level = ~preset_low;
        end else if (overflow && tov) begin
            s_next.level = max_on ? 1'b1 : ~s_reg.level;
        end else if (match && !max_on) begin
            unique case (action)
                ACT_TOG: s_next.level = ~s_reg.level;
                ACT_CLR: s_next.level = 1'b0;
                ACT_SET: s_next.level = 1'b1;
                ELS_OFF: s_next.level = s_reg.level;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            s_reg <= '{level: 1'b1, max_eff: 1'b0};
        end else begin
            s_reg <= s_next;
        end
    end

    assign level = s_reg.level;

    a_overflow_wins: assert property (@(posedge mclk) disable iff (!reset_n)
        (enabled && overflow && tov && !max_on) |=> (level != $past(level)))
        else $error("overflow toggle lost");
    a_preset_level: assert property (@(posedge mclk) disable iff (!reset_n)
        !enabled |=> (level == !$past(preset_low)))
        else $error("preset level wrong");
    a_full_duty: assert property (@(posedge mclk) disable iff (!reset_n)
        (enabled && max_on && overflow) ##1 (enabled && max_on) |-> level)
        else $error("full duty not high");
    a_duty_latency: assert property (@(posedge mclk) disable iff (!reset_n)
        !overflow |=> $stable(s_reg.max_eff))
        else $error("max duty changed mid period");
endmodule
`default_nettype wire

// [tmcc_top.sv]
// Our own choices: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Buffered-mode bit lives only in channel 0; reset clears it.
// - Buffered mode disables channel 1 register and frees its pin.
// - Edge bits nonzero: mode bit A picks capture (0) or compare (1).
// - Edge bits zero: pin left to port; bit A presets level, 1 low.
// - Disconnected channel drives its preset level until enabled.
// - Capture edge: 01 rising, 10 falling, 11 both.
// - Compare action: 00 none, 01 toggle, 10 clear, 11 set.
// - Active edge stores counter into value; compare uses written value.
// - Reading high value byte in capture blocks captures until low read.
// - Writing high byte in compare blocks compares and flag until low written.
// - Toggle-on-overflow toggles compare pin on every overflow except under max-duty with clear action.
// - Overflow toggle beats a simultaneous compare action.
// - Max-duty with toggle and clear action holds output high.
// - Max-duty changes act only from the next period.
// - Value registers have no meaningful reset contents.
// - Flag sets on compare match or on active capture edge.
// - Overflow event marks the period for toggles and PWM.
module tmcc_top (
    input  wire logic                  mclk,
    input  wire logic                  reset_n,
    input  wire logic [tmcc_pkg::AW-1:0] address,
    input  wire logic                  read,
    input  wire logic                  write,
    input  wire logic [tmcc_pkg::DW-1:0] writedata,
    output logic [tmcc_pkg::DW-1:0]    readdata,
    output logic                       waitrequest,
    input  wire logic [15:0]           counter_value,
    input  wire logic                  counter_overflow,
    input  wire logic                  counter_halt,
    input  wire logic [tmcc_pkg::NCH-1:0] channel_pin,
    output logic [tmcc_pkg::NCH-1:0]   channel_output_pin,
    output logic [tmcc_pkg::NCH-1:0]   channel_output_oe,
    output logic [tmcc_pkg::NCH-1:0]   channel_event_flag
);
    import tmcc_pkg::*;

    typedef struct packed {
        logic [NCH-1:0][7:0]  sc;
        logic [NCH-1:0][15:0] val;
        logic [NCH-1:0]       armed;
        logic [NCH-1:0]       cap_blk;
        logic [NCH-1:0]       cmp_blk;
        logic                 buf_sel;
        logic                 ack;
        logic [7:0]           rdata;
    } tmcc_state_t;

    tmcc_state_t s_reg;
    tmcc_state_t s_next;

    logic           buf_on;
    logic           wr;
    logic           rd;
    logic [7:0]     wd;
    logic [NCH-1:0] active;
    logic [NCH-1:0] capture;
    logic [NCH-1:0] compare;
    logic [NCH-1:0] oc_mode;
    logic [NCH-1:0] edge_hit;
    logic [NCH-1:0] cap_hit;
    logic [NCH-1:0] match;
    logic [NCH-1:0] set_ev;
    logic [NCH-1:0] wr_sc;
    logic [NCH-1:0] wr_hi;
    logic [NCH-1:0] wr_lo;
    logic [NCH-1:0] rd_sc;
    logic [NCH-1:0] rd_hi;
    logic [NCH-1:0] rd_lo;

    assign buf_on = s_reg.sc[0][BIT_BUF];
    // One wait state: the request is taken on the second edge
    assign waitrequest = (read | write) & ~s_reg.ack;
    assign wr = write & s_reg.ack;
    assign rd = read & s_reg.ack;
    assign wd = writedata[7:0];

    genvar i;
    generate
        for (i = 0; i < NCH; i++) begin : g_ch
            localparam logic [AW-1:0] A_SC = (i == 0) ? OFS_SC0 : OFS_SC1;
            localparam logic [AW-1:0] A_HI = (i == 0) ? OFS_V0H : OFS_V1H;
            localparam logic [AW-1:0] A_LO = (i == 0) ? OFS_V0L : OFS_V1L;
            logic        own_buf;
            logic        ch_en;
            logic [1:0]  els;
            logic        msa;
            logic [15:0] cmp_val;
            logic        blk;

            assign own_buf = (i == 0) ? buf_on : 1'b0;
            assign ch_en   = (i == 0) ? 1'b1 : ~buf_on;
            assign els     = s_reg.sc[i][BIT_ELSB:BIT_ELSA];
            assign msa     = s_reg.sc[i][BIT_MSA];

            assign active[i]  = ch_en & (els != ELS_OFF);
            assign capture[i] = active[i] & ~msa & ~own_buf;
            assign compare[i] = active[i] & (msa | own_buf);
            assign oc_mode[i] = msa | buf_on;

            // Channel 0 drives from whichever buffer is live this period
            assign cmp_val = own_buf ? (s_reg.buf_sel ? s_reg.val[1] : s_reg.val[0])
                                     : s_reg.val[i];
            assign blk = own_buf ? (|s_reg.cmp_blk) : s_reg.cmp_blk[i];

            assign match[i] = compare[i] & ~blk & (counter_value == cmp_val);
            // A stopped counter also inhibits captures
            assign cap_hit[i] = capture[i] & edge_hit[i] & ~s_reg.cap_blk[i]
                              & ~counter_halt;
            assign set_ev[i] = match[i] | cap_hit[i];

            assign wr_sc[i] = wr & (address == A_SC) & ch_en;
            assign wr_hi[i] = wr & (address == A_HI);
            assign wr_lo[i] = wr & (address == A_LO);
            assign rd_sc[i] = rd & (address == A_SC) & ch_en;
            assign rd_hi[i] = rd & (address == A_HI);
            assign rd_lo[i] = rd & (address == A_LO);

            tmcc_edge u_edge (
                .mclk     (mclk),
                .reset_n  (reset_n),
                .pin_in   (channel_pin[i]),
                .sel      (els),
                .edge_hit (edge_hit[i])
            );

            tmcc_pwm u_pwm (
                .mclk       (mclk),
                .reset_n    (reset_n),
                .enabled    (compare[i]),
                .preset_low (msa),
                .action     (els),
                .tov        (s_reg.sc[i][BIT_TOV]),
                .max_duty   (s_reg.sc[i][BIT_MAX]),
                .overflow   (counter_overflow),
                .match      (match[i]),
                .level      (channel_output_pin[i])
            );

            // Pin stays with the port unless a compare mode owns it
            assign channel_output_oe[i]  = compare[i];
            // Gated so a stale channel 1 flag never shows in the cycle buffering starts
            assign channel_event_flag[i] = s_reg.sc[i][BIT_FLAG] & ch_en;
        end
    endgenerate

    always_comb begin
        logic [7:0] nb;
        nb = 8'h00;
        s_next = s_reg;
        s_next.ack = (read | write) & ~s_reg.ack;

        unique case (address)
            OFS_SC0: s_next.rdata = s_reg.sc[0];
            OFS_SC1: s_next.rdata = buf_on ? 8'h00 : s_reg.sc[1];
            OFS_V0H: s_next.rdata = s_reg.val[0][15:8];
            OFS_V0L: s_next.rdata = s_reg.val[0][7:0];
            OFS_V1H: s_next.rdata = s_reg.val[1][15:8];
            OFS_V1L: s_next.rdata = s_reg.val[1][7:0];
            default: s_next.rdata = 8'h00;
        endcase

        // Buffer swap only at a period boundary
        if (!buf_on) begin
            s_next.buf_sel = 1'b0;
        end else if (counter_overflow) begin
            s_next.buf_sel = ~s_reg.buf_sel;
        end

        for (int k = 0; k < NCH; k++) begin
            if (rd_sc[k] && s_reg.sc[k][BIT_FLAG]) begin
                s_next.armed[k] = 1'b1;
            end
            if (wr_sc[k]) begin
                nb = wd & ((k == 0) ? SC_WMASK : SC1_WMASK);
                // Flag clears only by read-then-write-zero
                nb[BIT_FLAG] = s_reg.sc[k][BIT_FLAG]
                             & ~(s_reg.armed[k] & ~wd[BIT_FLAG]);
                s_next.sc[k] = nb;
                s_next.armed[k] = 1'b0;
            end
            if (rd_hi[k] && !oc_mode[k]) begin
                s_next.cap_blk[k] = 1'b1;
            end
            if (rd_lo[k]) begin
                s_next.cap_blk[k] = 1'b0;
            end
            if (wr_hi[k]) begin
                s_next.val[k][15:8] = wd;
                s_next.cmp_blk[k] = oc_mode[k];
            end
            if (wr_lo[k]) begin
                s_next.val[k][7:0] = wd;
                s_next.cmp_blk[k] = 1'b0;
            end
            if (cap_hit[k]) begin
                s_next.val[k] = counter_value;
            end
            // A new event beats a clear in the same cycle
            if (set_ev[k]) begin
                s_next.sc[k][BIT_FLAG] = 1'b1;
                s_next.armed[k] = 1'b0;
            end
        end
        if (buf_on) begin
            s_next.sc[1] = SC_RST;
            s_next.cap_blk[1] = 1'b0;
        end
    end

    // Value words reset to a harmless zero; nothing depends on it
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            s_reg.sc      <= {NCH{SC_RST}};
            s_reg.val     <= {NCH{VAL_RST}};
            s_reg.armed   <= '0;
            s_reg.cap_blk <= '0;
            s_reg.cmp_blk <= '0;
            s_reg.buf_sel <= 1'b0;
            s_reg.ack     <= 1'b0;
            s_reg.rdata   <= 8'h00;
        end else begin
            s_reg <= s_next;
        end
    end

    assign readdata = {24'h000000, s_reg.rdata};

    a_flag_on_match: assert property (@(posedge mclk) disable iff (!reset_n)
        match[0] |=> channel_event_flag[0])
        else $error("compare match did not set flag");
    a_capture_store: assert property (@(posedge mclk) disable iff (!reset_n)
        cap_hit[0] |=> (s_reg.val[0] == $past(counter_value)))
        else $error("capture value not stored");
    a_capture_block: assert property (@(posedge mclk) disable iff (!reset_n)
        (rd_hi[0] && capture[0]) ##1 (capture[0] && !rd_lo[0])[*2] |-> !cap_hit[0])
        else $error("capture not blocked after high read");
    a_compare_block: assert property (@(posedge mclk) disable iff (!reset_n)
        (wr_hi[0] && oc_mode[0]) |=> (!match[0] && s_reg.cmp_blk[0]))
        else $error("compare not blocked after high write");
    a_ch1_gated: assert property (@(posedge mclk) disable iff (!reset_n)
        buf_on |-> (!channel_output_oe[1] && !channel_event_flag[1]))
        else $error("channel 1 active in buffered mode");
    a_buf_swap: assert property (@(posedge mclk) disable iff (!reset_n)
        (buf_on && !wr_sc[0]) |=> (s_reg.buf_sel == ($past(s_reg.buf_sel) ^ $past(counter_overflow))))
        else $error("buffer swap off the overflow");
    a_bus_answer: assert property (@(posedge mclk) disable iff (!reset_n)
        ((read || write) && waitrequest) ##1 (read || write) |-> !waitrequest)
        else $error("bus answer late");
    a_flag_sticky: assert property (@(posedge mclk) disable iff (!reset_n)
        (channel_event_flag[0] && !wr_sc[0]) |=> channel_event_flag[0])
        else $error("flag dropped without clear");

    c_capture: cover property (@(posedge mclk) disable iff (!reset_n) cap_hit[0]);
    c_match: cover property (@(posedge mclk) disable iff (!reset_n) match[1]);
    c_buffered: cover property (@(posedge mclk) disable iff (!reset_n)
        buf_on && counter_overflow && match[0]);
endmodule
`default_nettype wire

// [tmcc_pin_model.sv]
`timescale 1ns/1ps
`default_nettype none
module tmcc_pin_model (
    input  wire logic [tmcc_pkg::NCH-1:0] ext_level,
    input  wire logic [tmcc_pkg::NCH-1:0] out_level,
    input  wire logic [tmcc_pkg::NCH-1:0] out_en,
    output logic [tmcc_pkg::NCH-1:0]      pin
);
    import tmcc_pkg::*;
    // The outside driver yields wherever the channel drives, so no contention is modelled
    // Outside level moves only when the bench asks, never glitching in between
    assign pin = (out_en & out_level) | (~out_en & ext_level);
endmodule
`default_nettype wire

// [tmcc_top_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin error_cnt++; $display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tmcc_top_tb;
    import tmcc_pkg::*;
    logic           mclk;
    logic           reset_n;
    logic [AW-1:0]  address;
    logic           read;
    logic           write;
    logic [DW-1:0]  writedata;
    logic [DW-1:0]  readdata;
    logic           waitrequest;
    logic [15:0]    counter_value;
    logic           counter_overflow;
    logic           counter_halt;
    logic [NCH-1:0] ext_level;
    logic [NCH-1:0] pin;
    logic [NCH-1:0] out_pin;
    logic [NCH-1:0] out_oe;
    logic [NCH-1:0] flag;
    logic [7:0]     rd;
    logic [1:0]     acts [4];
    logic           exps [4];
    int             error_cnt;
    int             n_compared;
    int             cyc;
    int             i;

    tmcc_top u_dut (
        .mclk               (mclk),
        .reset_n            (reset_n),
        .address            (address),
        .read               (read),
        .write              (write),
        .writedata          (writedata),
        .readdata           (readdata),
        .waitrequest        (waitrequest),
        .counter_value      (counter_value),
        .counter_overflow   (counter_overflow),
        .counter_halt       (counter_halt),
        .channel_pin        (pin),
        .channel_output_pin (out_pin),
        .channel_output_oe  (out_oe),
        .channel_event_flag (flag)
    );

    tmcc_pin_model u_pins (
        .ext_level (ext_level),
        .out_level (out_pin),
        .out_en    (out_oe),
        .pin       (pin)
    );

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask

    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic bus_wr(input logic [AW-1:0] a, input logic [7:0] d);
        @(posedge mclk);
        address   <= a;
        writedata <= {24'h000000, d};
        write     <= 1'b1;
        do tick(1); while (waitrequest !== 1'b0);
        write <= 1'b0;
    endtask

    task automatic bus_rd(input logic [AW-1:0] a, output logic [7:0] d);
        @(posedge mclk);
        address <= a;
        read    <= 1'b1;
        do tick(1); while (waitrequest !== 1'b0);
        d = readdata[7:0];
        read <= 1'b0;
    endtask

    // Mode writes happen with the counter halted and cleared
    task automatic set_sc(input logic [AW-1:0] a, input logic [7:0] d);
        @(posedge mclk);
        counter_halt  <= 1'b1;
        counter_value <= 16'h0000;
        bus_wr(a, d);
        counter_halt <= 1'b0;
    endtask

    // Flag clear needs a read of the register before the write of zero
    task automatic clr(input logic [AW-1:0] a, input logic [7:0] d);
        bus_rd(a, rd);
        set_sc(a, d);
    endtask

    task automatic pulse(input logic [15:0] v, input logic o);
        @(posedge mclk);
        counter_value    <= v;
        counter_overflow <= o;
        @(posedge mclk);
        counter_value    <= v + 16'h0001;
        counter_overflow <= 1'b0;
        tick(2);
    endtask

    task automatic pin_set(input int ch, input logic l);
        @(posedge mclk);
        ext_level[ch] <= l;
        tick(4);
    endtask

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            print_verdict();
        end
    end

    initial begin
        reset_n = 1'b0;
        address = '0;
        read = 1'b0;
        write = 1'b0;
        writedata = '0;
        counter_value = 16'h0000;
        counter_overflow = 1'b0;
        counter_halt = 1'b0;
        ext_level = '0;
        acts = '{ACT_SET, ACT_CLR, ACT_TOG, ACT_TOG};
        exps = '{1'b1, 1'b0, 1'b1, 1'b0};
        tick(2);
        `CHK(out_pin, 2'b11)
        `CHK(out_oe, 2'b00)
        `CHK(flag, 2'b00)
        reset_n <= 1'b1;
        bus_rd(OFS_SC0, rd);
        `CHK(rd, 8'h00)
        bus_wr(OFS_SC1, 8'h20);
        bus_rd(OFS_SC1, rd);
        `CHK(rd, 8'h00)
        bus_rd(5'h18, rd);
        `CHK(rd, 8'h00)
        set_sc(OFS_SC0, 8'h10);
        tick(2);
        `CHK(out_pin[0], 1'b0)
        `CHK(out_oe[0], 1'b0)
        // Capture on any edge, then the high-byte read lock
        set_sc(OFS_SC0, 8'h0c);
        counter_value <= 16'h1234;
        pin_set(0, 1'b1);
        `CHK(flag[0], 1'b1)
        bus_rd(OFS_V0H, rd);
        `CHK(rd, 8'h12)
        counter_value <= 16'h5678;
        pin_set(0, 1'b0);
        bus_rd(OFS_V0L, rd);
        `CHK(rd, 8'h34)
        pin_set(0, 1'b1);
        bus_rd(OFS_V0H, rd);
        `CHK(rd, 8'h56)
        bus_rd(OFS_V0L, rd);
        `CHK(rd, 8'h78)
        // Each capture edge code on channel 1
        for (i = 1; i < 4; i++) begin
            clr(OFS_SC1, {4'h0, 2'(i), 2'h0});
            pin_set(1, 1'b1);
            `CHK(flag[1], (i != 2))
            clr(OFS_SC1, {4'h0, 2'(i), 2'h0});
            pin_set(1, 1'b0);
            `CHK(flag[1], (i != 1))
        end
        // Compare actions on channel 0
        clr(OFS_SC0, 8'h1c);
        bus_wr(OFS_V0H, 8'h00);
        bus_wr(OFS_V0L, 8'h60);
        for (i = 0; i < 4; i++) begin
            set_sc(OFS_SC0, {3'h0, 1'b1, acts[i], 2'h0});
            pulse(16'h0060, 1'b0);
            `CHK(out_pin[0], exps[i])
            `CHK(out_oe[0], 1'b1)
        end
        `CHK(flag[0], 1'b1)
        clr(OFS_SC0, 8'h14);
        bus_wr(OFS_V0H, 8'h00);
        pulse(16'h0060, 1'b0);
        `CHK(flag[0], 1'b0)
        `CHK(out_pin[0], 1'b0)
        bus_wr(OFS_V0L, 8'h70);
        pulse(16'h0070, 1'b0);
        `CHK(flag[0], 1'b1)
        `CHK(out_pin[0], 1'b1)
        // Overflow toggle, priority and forced full duty
        set_sc(OFS_SC0, 8'h1a);
        pulse(16'hff00, 1'b1);
        `CHK(out_pin[0], 1'b0)
        pulse(16'h0070, 1'b1);
        `CHK(out_pin[0], 1'b1)
        set_sc(OFS_SC0, 8'h1b);
        pulse(16'h0070, 1'b0);
        `CHK(out_pin[0], 1'b0)
        pulse(16'hff00, 1'b1);
        `CHK(out_pin[0], 1'b1)
        pulse(16'h0070, 1'b0);
        `CHK(out_pin[0], 1'b1)
        set_sc(OFS_SC0, 8'h1a);
        pulse(16'h0070, 1'b0);
        `CHK(out_pin[0], 1'b1)
        set_sc(OFS_SC0, 8'h18);
        pulse(16'h0070, 1'b0);
        pulse(16'hff00, 1'b1);
        `CHK(out_pin[0], 1'b0)
        // Buffered mode alternates the value registers at overflow
        set_sc(OFS_SC1, 8'h00);
        bus_wr(OFS_V1H, 8'h00);
        bus_wr(OFS_V1L, 8'h80);
        set_sc(OFS_SC0, 8'h24);
        set_sc(OFS_SC1, 8'h14);
        bus_rd(OFS_SC1, rd);
        `CHK(rd, 8'h00)
        `CHK(out_oe[1], 1'b0)
        `CHK(flag[1], 1'b0)
        pulse(16'h0080, 1'b0);
        `CHK(out_pin[0], 1'b0)
        pulse(16'h0070, 1'b0);
        `CHK(out_pin[0], 1'b1)
        pulse(16'hff00, 1'b1);
        pulse(16'h0070, 1'b0);
        `CHK(out_pin[0], 1'b1)
        pulse(16'h0080, 1'b0);
        `CHK(out_pin[0], 1'b0)
        bus_rd(OFS_SC0, rd);
        `CHK(rd, 8'ha4)
        print_verdict();
    end
endmodule
`default_nettype wire
